// File: hw/ptu_pkg.sv
// Package of constants and types for the periodic timer unit.
package ptu_pkg;
  // Register indices on the plain register port.
  localparam logic [2:0] REG_RUN    = 3'h0;
  localparam logic [2:0] REG_CTRL   = 3'h1;
  localparam logic [2:0] REG_COUNT  = 3'h2;
  localparam logic [2:0] REG_CMPA   = 3'h3;
  localparam logic [2:0] REG_PERIOD = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  // Field positions.
  localparam int RUN_BIT     = 0;
  localparam int STAT_A_BIT  = 0;
  localparam int STAT_P_BIT  = 1;
  // Mode field encodings.
  localparam logic [1:0] MODE_CMP   = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] MODE_TC    = 2'h3;
  // Pin-action encodings.
  localparam logic [1:0] PA_NONE    = 2'h0;
  localparam logic [1:0] PA_LOW     = 2'h1;
  localparam logic [1:0] PA_HIGH    = 2'h2;
  localparam logic [1:0] PA_TOGGLE  = 2'h3;
  // Counter limits and reset values.
  localparam logic [9:0] CNT_ZERO   = 10'h000;
  localparam logic [9:0] CNT_MAX    = 10'h3ff;
  localparam logic [9:0] CNT_ONE    = 10'h001;
  // Control field layout, as written over the register port.
  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] pin_action;
    logic       initial_level;
    logic       output_invert;
    logic       reserved;
    logic       clear_select;
  } ptu_ctrl_t;
  localparam ptu_ctrl_t CTRL_RESET = '0;
endpackage : ptu_pkg

// File: hw/ptu_timer.sv
// Periodic timer unit: counter, two comparators, flags and output pin.
// Functional notes
// - Mode field 00 compare, 11 timer; 10 with action 00 to 10 PWM, 11 pulse.
// - Compare mode, clear-select low: clear on period match, both flags.
// - Compare mode, clear-select high: clear on compare A, no period flag.
// - Compare A zero: no compare A flag; counter wraps at 3FF with clear-select high.
// - In compare mode compare A matches move the output pin; period matches do not.
// - Compare A match drives pin high, low or toggles per pin action.
// - Pin action 00 none, 01 low, 10 high, 11 toggle.
// - Run bit rising sets the pin to the initial level in compare and pulse modes.
// - Run rise zeroes the counter; run fall holds its value.
// - Timer mode counts and flags like compare mode, pin not driven.
// - PWM: period value sets period, zero means 1024; A sets duty.
// - PWM raises flags on every compare A and period match.
// - PWM duty at or above period gives full duty.
// - PWM polarity from initial level, action forces or enables, invert.
// - PWM counting continues while the pin is forced.
// - Pulse mode: run rise starts counter and pulse leading edge.
// - Pulse mode: trigger pin edge sets the run bit.
// - Pulse ends on run clear or compare A match, which clears run.
// - Pulse mode: counter zeroed only by run rise, period unused.
`timescale 1ns/10ps
module ptu_timer (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port.
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // Timer clock tick from the clock selector.
  input  wire logic        timer_tick,
  // External trigger pin.
  input  wire logic        ext_trigger_pin,
  // Output pin and flags.
  output logic             pin_out,
  output logic             pin_oe,
  output logic             compare_a_flag,
  output logic             period_match_flag
);
  ptu_pkg::ptu_ctrl_t ctrl_reg;
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic [9:0] cmpa_reg;
  logic [9:0] period_reg;
  logic       run_reg;
  logic       run_next;
  logic       run_prev_reg;
  logic       cm_level_reg;
  logic       cm_level_next;
  logic       pin_next;
  logic [2:0] trig_sync_reg;
  logic       trig_level_reg;
  logic [15:0] rdata_next;

  // Trigger pin passes three flops; a change counts once two agree.
  wire trig_stable = trig_sync_reg[1] == trig_sync_reg[2];
  wire trig_rise   = trig_stable & trig_sync_reg[1] & ~trig_level_reg;

  // Mode decode from the mode and pin-action fields.
  wire mode_cm   = ctrl_reg.mode_select == ptu_pkg::MODE_CMP;
  wire mode_tc   = ctrl_reg.mode_select == ptu_pkg::MODE_TC;
  wire mode_pp   = ctrl_reg.mode_select == ptu_pkg::MODE_PULSE;
  wire mode_sp   = mode_pp & (ctrl_reg.pin_action == ptu_pkg::PA_TOGGLE);
  wire mode_pwm  = mode_pp & ~mode_sp;
  wire mode_cmtc = mode_cm | mode_tc;

  // Comparators look at the next count so a zero period wraps at 3FF.
  wire       run_rise  = run_reg & ~run_prev_reg;
  wire       step      = run_reg & ~run_rise & timer_tick;
  wire [9:0] cnt_plus  = cnt_reg + ptu_pkg::CNT_ONE;
  wire       cmpa_zero = cmpa_reg == ptu_pkg::CNT_ZERO;
  wire       a_hit     = step & (cnt_plus == cmpa_reg) & ~cmpa_zero;
  wire       p_hit     = step & (cnt_plus == period_reg);

  // Clear choice per mode; pulse mode never clears on a match.
  wire clr_cmtc = ctrl_reg.clear_select ? a_hit : p_hit;
  wire clr_hit  = (mode_cmtc & clr_cmtc) | (mode_pwm & p_hit);

  // Flag sources; the period flag is muted by clear-select high in compare and timer modes.
  wire set_a = a_hit & ~mode_pp | a_hit & mode_pp;
  wire set_p = p_hit & (mode_pwm | mode_cmtc & ~ctrl_reg.clear_select);

  // PWM level: full duty once duty reaches the period.
  wire full_duty = (period_reg != ptu_pkg::CNT_ZERO) &
                   (cmpa_reg >= period_reg);
  wire pwm_act   = run_reg & ((cnt_reg < cmpa_reg) | full_duty);
  wire pwm_sel   = ctrl_reg.pin_action == ptu_pkg::PA_HIGH ? pwm_act :
                   ctrl_reg.pin_action[0];
  wire pwm_lvl   = pwm_sel ? ctrl_reg.initial_level :
                   ~ctrl_reg.initial_level;
  wire sp_lvl    = run_reg ? ctrl_reg.initial_level :
                   ~ctrl_reg.initial_level;

  // Register write decode.
  wire wr_run    = reg_write & (reg_addr == ptu_pkg::REG_RUN);
  wire wr_ctrl   = reg_write & (reg_addr == ptu_pkg::REG_CTRL);
  wire wr_cmpa   = reg_write & (reg_addr == ptu_pkg::REG_CMPA);
  wire wr_period = reg_write & (reg_addr == ptu_pkg::REG_PERIOD);
  wire wr_status = reg_write & (reg_addr == ptu_pkg::REG_STATUS);
  wire clr_a = wr_status & reg_wdata[ptu_pkg::STAT_A_BIT];
  wire clr_p = wr_status & reg_wdata[ptu_pkg::STAT_P_BIT];

  // Run bit: software write, then hardware stop, then trigger; set wins.
  always_comb
  begin
    run_next = run_reg;
    if (wr_run)
      run_next = reg_wdata[ptu_pkg::RUN_BIT];
    if (mode_sp & a_hit)
      run_next = 1'b0;
    if (mode_sp & trig_rise)
      run_next = 1'b1;
  end

  // Counter: zero on run rise, hold when stopped, clear on selected match.
  always_comb
  begin
    cnt_next = cnt_reg;
    if (run_rise)
      cnt_next = ptu_pkg::CNT_ZERO;
    else if (step)
      cnt_next = clr_hit ? ptu_pkg::CNT_ZERO : cnt_plus;
  end

  // Compare-mode level: initial on run rise, compare A action otherwise.
  always_comb
  begin
    cm_level_next = cm_level_reg;
    if (run_rise)
      cm_level_next = ctrl_reg.initial_level;
    else if (a_hit)
    begin
      case (ctrl_reg.pin_action)
        ptu_pkg::PA_LOW:    cm_level_next = 1'b0;
        ptu_pkg::PA_HIGH:   cm_level_next = 1'b1;
        ptu_pkg::PA_TOGGLE: cm_level_next = ~cm_level_reg;
        default:            cm_level_next = cm_level_reg;
      endcase
    end
  end

  // Pin selection; the invert bit sits last so it reverses compare, PWM and pulse modes.
  always_comb
  begin
    pin_next = pin_out;
    if (mode_cm)
      pin_next = cm_level_next ^ ctrl_reg.output_invert;
    else if (mode_pwm)
      pin_next = pwm_lvl ^ ctrl_reg.output_invert;
    else if (mode_sp)
      pin_next = sp_lvl ^ ctrl_reg.output_invert;
  end

  // Read mux; unmapped indices read as zero.
  always_comb
  begin
    rdata_next = 16'h0000;
    case (reg_addr)
      ptu_pkg::REG_RUN:    rdata_next = {15'h0000, run_reg};
      ptu_pkg::REG_CTRL:   rdata_next = {8'h00, ctrl_reg};
      ptu_pkg::REG_COUNT:  rdata_next = {6'h00, cnt_reg};
      ptu_pkg::REG_CMPA:   rdata_next = {6'h00, cmpa_reg};
      ptu_pkg::REG_PERIOD: rdata_next = {6'h00, period_reg};
      ptu_pkg::REG_STATUS: rdata_next = {14'h0000, period_match_flag,
                                         compare_a_flag};
      default:             rdata_next = 16'h0000;
    endcase
    if (!reg_read)
      rdata_next = 16'h0000;
  end

  // Software registers and run tracking.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_reg     <= ptu_pkg::CTRL_RESET;
      cmpa_reg     <= ptu_pkg::CNT_ZERO;
      period_reg   <= ptu_pkg::CNT_ZERO;
      run_reg      <= 1'b0;
      run_prev_reg <= 1'b0;
      reg_rdata    <= 16'h0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= reg_wdata[7:0];
      if (wr_cmpa)
        cmpa_reg <= reg_wdata[9:0];
      if (wr_period)
        period_reg <= reg_wdata[9:0];
      run_reg      <= run_next;
      run_prev_reg <= run_reg;
      reg_rdata    <= rdata_next;
    end
  end

  // Counter, pin and sticky flags; a new event beats a clear.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_reg           <= ptu_pkg::CNT_ZERO;
      cm_level_reg      <= 1'b0;
      pin_out           <= 1'b0;
      pin_oe            <= 1'b0;
      compare_a_flag    <= 1'b0;
      period_match_flag <= 1'b0;
    end
    else
    begin
      cnt_reg           <= cnt_next;
      cm_level_reg      <= cm_level_next;
      pin_out           <= pin_next;
      pin_oe            <= ~mode_tc;
      compare_a_flag    <= set_a | (compare_a_flag & ~clr_a);
      period_match_flag <= set_p | (period_match_flag & ~clr_p);
    end
  end

  // Trigger synchroniser and filtered level.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      trig_sync_reg  <= 3'h0;
      trig_level_reg <= 1'b0;
    end
    else
    begin
      trig_sync_reg <= {trig_sync_reg[1:0], ext_trigger_pin};
      if (trig_stable)
        trig_level_reg <= trig_sync_reg[1];
    end
  end

  // Checks on counter, flags and pin behaviour.
  AST_RISE_CLR: assert property (@(posedge clk) disable iff (reset)
    run_rise |=> cnt_reg == ptu_pkg::CNT_ZERO)
    else $error("Counter not zeroed after run rise.");
  AST_STOP_HOLD: assert property (@(posedge clk) disable iff (reset)
    !run_reg |=> $stable(cnt_reg))
    else $error("Counter moved while stopped.");
  AST_STEP: assert property (@(posedge clk) disable iff (reset)
    (step & !clr_hit) |=> cnt_reg == $past(cnt_reg) + 10'h001)
    else $error("Counter did not step on tick.");
  AST_CS1_NO_PF: assert property (@(posedge clk) disable iff (reset)
    (mode_cmtc & ctrl_reg.clear_select & !period_match_flag)
    |=> !period_match_flag)
    else $error("Period flag raised with clear-select high.");
  AST_A_ZERO: assert property (@(posedge clk) disable iff (reset)
    (cmpa_zero & !compare_a_flag) |=> !compare_a_flag)
    else $error("Compare A flag raised with zero compare value.");
  AST_INIT_LVL: assert property (@(posedge clk) disable iff (reset)
    (run_rise & mode_cm) |=> cm_level_reg == $past(ctrl_reg.initial_level))
    else $error("Pin level not initialised on run rise.");
  AST_TC_FREE: assert property (@(posedge clk) disable iff (reset)
    mode_tc |=> !pin_oe)
    else $error("Pin driven in timer mode.");
  AST_SP_STOP: assert property (@(posedge clk) disable iff (reset)
    (mode_sp & a_hit & !trig_rise) |=> !run_reg)
    else $error("Run bit not cleared by compare A in pulse mode.");
  AST_SP_TRIG: assert property (@(posedge clk) disable iff (reset)
    (mode_sp & trig_rise) |=> run_reg)
    else $error("Trigger edge did not set run bit.");
  AST_FULL_DUTY: assert property (@(posedge clk) disable iff (reset)
    (mode_pwm & full_duty & run_reg &
     ctrl_reg.pin_action == ptu_pkg::PA_HIGH & !wr_ctrl)
    |=> pin_out == (ctrl_reg.initial_level ^ ctrl_reg.output_invert))
    else $error("Full duty not held.");
  AST_PWM_CLR: assert property (@(posedge clk) disable iff (reset)
    (mode_pwm & p_hit) |=> cnt_reg == ptu_pkg::CNT_ZERO)
    else $error("Period match did not clear the counter in PWM mode.");
  AST_PWM_FLAG: assert property (@(posedge clk) disable iff (reset)
    (mode_pwm & p_hit) |=> period_match_flag)
    else $error("Period flag not raised in PWM mode.");
  AST_SP_NO_CLR: assert property (@(posedge clk) disable iff (reset)
    (mode_sp & step) |=> cnt_reg == $past(cnt_plus))
    else $error("Counter cleared by a match in pulse mode.");
  AST_CM_HOLD: assert property (@(posedge clk) disable iff (reset)
    (mode_cm & $stable(ctrl_reg) & p_hit & !a_hit & !run_rise)
    |=> $stable(pin_out))
    else $error("Period match moved the pin in compare mode.");

  // Main scenarios.
  COV_CM_TOGGLE: cover property (@(posedge clk) disable iff (reset)
    mode_cm & a_hit & ctrl_reg.pin_action == ptu_pkg::PA_TOGGLE);
  COV_PWM_WRAP: cover property (@(posedge clk) disable iff (reset)
    mode_pwm & p_hit);
  COV_SP_TRIG: cover property (@(posedge clk) disable iff (reset)
    mode_sp & trig_rise ##[1:200] (mode_sp & a_hit));
  COV_CS1_CLR: cover property (@(posedge clk) disable iff (reset)
    mode_cm & ctrl_reg.clear_select & a_hit);
  COV_PWM_FULL: cover property (@(posedge clk) disable iff (reset)
    mode_pwm & full_duty & run_reg);
endmodule : ptu_timer

// File: test/ptu_ext_model.sv
// Model of the board circuitry on the trigger and output pins.
`timescale 1ns/10ps
module ptu_ext_model (
  // Clock.
  input  wire logic clk,
  // Pins of the timer.
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      ext_trigger_pin,
  output logic      pin_line
);
  // A pull-up holds the line high whenever the timer lets it go.
  assign pin_line = pin_oe ? pin_out : 1'b1;
  initial ext_trigger_pin = 1'b0;
  // The edge is held well past the input filter, else it would be lost.
  task automatic fire();
    @(posedge clk);
    ext_trigger_pin <= 1'b1;
    repeat (8) @(posedge clk);
    ext_trigger_pin <= 1'b0;
  endtask : fire
endmodule : ptu_ext_model

// File: test/ptu_timer_tb.sv
// Self-checking bench for the periodic timer unit.
`timescale 1ns/10ps
module ptu_timer_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        timer_tick = 1'b0;
  logic [15:0] reg_rdata;
  logic        ext_trigger_pin;
  logic        pin_out;
  logic        pin_oe;
  logic        pin_line;
  logic        compare_a_flag;
  logic        period_match_flag;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  ptu_timer dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timer_tick(timer_tick),
    .ext_trigger_pin(ext_trigger_pin), .pin_out(pin_out),
    .pin_oe(pin_oe), .compare_a_flag(compare_a_flag),
    .period_match_flag(period_match_flag));
  ptu_ext_model partner (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_trigger_pin(ext_trigger_pin), .pin_line(pin_line));

  // Clock of 20 ns, and a ceiling so a hang still ends in a verdict.
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string w, input logic [15:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge.
  task automatic chk_rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk($sformatf("reg %0d", a), e, reg_rdata);
  endtask : chk_rd

  task automatic setup(input logic [15:0] c, a, p, input logic tk);
    wr(ptu_pkg::REG_RUN, 16'h0000);
    wr(ptu_pkg::REG_CTRL, c);
    wr(ptu_pkg::REG_CMPA, a);
    wr(ptu_pkg::REG_PERIOD, p);
    wr(ptu_pkg::REG_STATUS, 16'h0003);
    timer_tick <= tk;
  endtask : setup

  // Counts pin changes and high samples over n cycles.
  task automatic sample(input int n, input logic [15:0] ec, eh);
    logic prev;
    int   c;
    int   h;
    @(posedge clk);
    #1 prev = pin_out;
    c = 0;
    h = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1 c += int'(pin_out !== prev);
      h += int'(pin_out === 1'b1);
      prev = pin_out;
    end
    chk("pin changes", ec, 16'(c));
    chk("pin highs", eh, 16'(h));
  endtask : sample

  task automatic wait_pin(input logic v);
    for (int i = 0; i < 40 && pin_out !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("pin_out", {15'h0000, v}, {15'h0000, pin_out});
  endtask : wait_pin

  task automatic t_regs();
    chk_rd(ptu_pkg::REG_CTRL, 16'h0000);
    wr(ptu_pkg::REG_COUNT, 16'h0005);
    chk_rd(ptu_pkg::REG_COUNT, 16'h0000);
    chk_rd(3'h7, 16'h0000);
  endtask : t_regs

  // Compare A kept nonzero in compare mode by the bench.
  task automatic t_count();
    setup(16'h0028, 16'h03ff, 16'h0000, 1'b0);
    wr(ptu_pkg::REG_RUN, 16'h0001);
    repeat (3) @(posedge clk);
    #1 chk("pin_out", 16'h0001, {15'h0000, pin_out});
    @(posedge clk);
    timer_tick <= 1'b1;
    repeat (5) @(posedge clk);
    timer_tick <= 1'b0;
    chk_rd(ptu_pkg::REG_COUNT, 16'h0005);
    wr(ptu_pkg::REG_RUN, 16'h0000);
    timer_tick <= 1'b1;
    repeat (8) @(posedge clk);
    timer_tick <= 1'b0;
    chk_rd(ptu_pkg::REG_COUNT, 16'h0005);
    wr(ptu_pkg::REG_RUN, 16'h0001);
    repeat (2) @(posedge clk);
    chk_rd(ptu_pkg::REG_COUNT, 16'h0000);
  endtask : t_count

  // Period match alone must not move the pin; then each pin action.
  task automatic t_cmp();
    setup(16'h0020, 16'h0003, 16'h0002, 1'b1);
    wr(ptu_pkg::REG_RUN, 16'h0001);
    repeat (20) @(posedge clk);
    chk_rd(ptu_pkg::REG_STATUS, 16'h0002);
    chk("pin_out", 16'h0000, {15'h0000, pin_out});
    wr(ptu_pkg::REG_CMPA, 16'h0001);
    wait_pin(1'b1);
    chk_rd(ptu_pkg::REG_STATUS, 16'h0003);
    wr(ptu_pkg::REG_CTRL, 16'h0010);
    wait_pin(1'b0);
    wr(ptu_pkg::REG_CTRL, 16'h0030);
    sample(8, 16'h0004, 16'h0004);
    wr(ptu_pkg::REG_CTRL, 16'h0020);
    wait_pin(1'b1);
    wr(ptu_pkg::REG_CTRL, 16'h0000);
    sample(8, 16'h0000, 16'h0008);
  endtask : t_cmp

  task automatic t_clr_a();
    setup(16'h0031, 16'h0003, 16'h0002, 1'b1);
    wr(ptu_pkg::REG_RUN, 16'h0001);
    repeat (20) @(posedge clk);
    chk_rd(ptu_pkg::REG_STATUS, 16'h0001);
  endtask : t_clr_a

  task automatic t_timer();
    setup(16'h00c0, 16'h0000, 16'h0003, 1'b1);
    wr(ptu_pkg::REG_RUN, 16'h0001);
    repeat (20) @(posedge clk);
    chk_rd(ptu_pkg::REG_STATUS, 16'h0002);
    chk("pin_line", 16'h0001, {15'h0000, pin_line});
    setup(16'h00c0, 16'h0000, 16'h0000, 1'b0);
    wr(ptu_pkg::REG_RUN, 16'h0001);
    repeat (2) @(posedge clk);
    timer_tick <= 1'b1;
    repeat (1030) @(posedge clk);
    timer_tick <= 1'b0;
    chk_rd(ptu_pkg::REG_COUNT, 16'h0006);
  endtask : t_timer

  task automatic t_pwm();
    setup(16'h00a8, 16'h0001, 16'h0004, 1'b1);
    wr(ptu_pkg::REG_RUN, 16'h0001);
    sample(8, 16'h0004, 16'h0002);
    chk_rd(ptu_pkg::REG_STATUS, 16'h0003);
    wr(ptu_pkg::REG_CMPA, 16'h0004);
    sample(8, 16'h0000, 16'h0008);
    wr(ptu_pkg::REG_CTRL, 16'h00ac);
    sample(8, 16'h0000, 16'h0000);
    wr(ptu_pkg::REG_CTRL, 16'h0098);
    sample(8, 16'h0000, 16'h0008);
    wr(ptu_pkg::REG_CTRL, 16'h0088);
    wr(ptu_pkg::REG_STATUS, 16'h0003);
    sample(8, 16'h0000, 16'h0000);
    chk_rd(ptu_pkg::REG_STATUS, 16'h0003);
  endtask : t_pwm

  // Action 11 is set once and left alone for the whole pulse.
  task automatic t_pulse();
    setup(16'h00b8, 16'h0006, 16'h0001, 1'b1);
    partner.fire();
    wait_pin(1'b1);
    wait_pin(1'b0);
    chk_rd(ptu_pkg::REG_RUN, 16'h0000);
    chk_rd(ptu_pkg::REG_STATUS, 16'h0001);
    chk_rd(ptu_pkg::REG_COUNT, 16'h0006);
  endtask : t_pulse

  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("pin_oe", 16'h0001, {15'h0000, pin_oe});
    t_regs();
    t_count();
    t_cmp();
    t_clr_a();
    t_timer();
    t_pwm();
    t_pulse();
    complete_run();
  end
endmodule : ptu_timer_tb
